// ### rtl/dac_sample_input_interface.v
// digital sample input of a 14-bit current-steering converter
// assumes sample_word is synchronous to sys_clk; sys_clk is the sample clock
`include "dac_input_map.vh"
`default_nettype none
module dac_sample_input_interface #(
  parameter WIDTH = `SAMPLE_WIDTH
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  // sample source
  input  wire [WIDTH-1:0] sample_word,
  input  wire             sample_valid,
  output reg              sample_ready,
  input  wire             format_twos,
  input  wire             sleep,
  // converter paths
  output reg  [WIDTH-1:0] pos_current_path,
  output reg  [WIDTH-1:0] neg_current_path,
  output reg              paths_enabled,
  input  wire             sink_ready
);
  wire             buf_push;
  wire             next_full;
  wire             buf_in_ready;
  wire             buf_out_valid;
  wire [WIDTH-1:0] buf_out_data;
  wire             drain;
  wire [WIDTH-1:0] code;
  wire [WIDTH-1:0] full_code;

  assign full_code = {WIDTH{1'b1}};

  // the format pin is sampled with the word so a change affects only later samples
  function [WIDTH-1:0] to_code;
    input [WIDTH-1:0] word;
    input             twos;
    begin
      if (twos == `FMT_TWOS)
        to_code = {~word[WIDTH-1], word[WIDTH-2:0]};
      else
        to_code = word;
    end
  endfunction

  assign code = to_code(sample_word, format_twos);

  // the word goes straight into the buffer so the paths follow one clock later
  assign buf_push  = sample_valid & sample_ready;
  // ready is a flop, so it follows the buffer's next fill level, not its current one
  assign next_full = (~buf_in_ready & ~drain) | (buf_in_ready & buf_out_valid & buf_push & ~drain);

  // a stalled sink backs up into the buffer, never drops a word
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      sample_ready <= 1'b0;
    else
      sample_ready <= ~next_full;
  end

  skid_buffer #(
    .WIDTH (WIDTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (buf_push),
    .in_data   (code),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (sink_ready)
  );

  assign drain = buf_out_valid & sink_ready;

  // outputs hold the last code until a new one drains; sleep forces zero current
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos_current_path <= `CODE_ZERO;
      neg_current_path <= `CODE_ZERO;
      paths_enabled    <= 1'b0;
    end
    else
    begin
      paths_enabled <= ~sleep;
      if (sleep)
      begin
        pos_current_path <= `CODE_ZERO;
        neg_current_path <= `CODE_ZERO;
      end
      else if (drain)
      begin
        pos_current_path <= buf_out_data;
        neg_current_path <= full_code - buf_out_data;
      end
    end
  end
endmodule // dac_sample_input_interface
`default_nettype wire

// ### rtl/dac_input_map.vh
// constants for the sample input path of the converter
// assumes inclusion by bare name from the rtl files
`ifndef DAC_INPUT_MAP_VH
`define DAC_INPUT_MAP_VH
`define SAMPLE_WIDTH     14
`define SAMPLE_MSB       13
`define CODE_FULL        14'h3fff
`define CODE_ZERO        14'h0000
`define FMT_BINARY       1'b0
`define FMT_TWOS         1'b1
`define SKID_DEPTH       2
`endif

// ### rtl/skid_buffer.v
// two-entry valid/ready buffer for one data word
// assumes one clock, asynchronous active-low reset
`default_nettype none
module skid_buffer #(
  parameter WIDTH = 14
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             reset_n,
  // fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // drain side
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg  [WIDTH-1:0] mem_r [0:1];
  reg              wr_ptr_r;
  reg              rd_ptr_r;
  reg  [1:0]       count_r;
  wire             push;
  wire             pop;

  assign in_ready  = (count_r != 2'd2);
  assign out_valid = (count_r != 2'd0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge sys_clk)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        count_r <= count_r + 2'd1;
      else if (pop && !push)
        count_r <= count_r - 2'd1;
    end
  end
endmodule // skid_buffer
`default_nettype wire

// ### verif/dac_props_properties.sv
// assertions on the converter ports; bound to the top module below
`default_nettype none
module dac_props(input wire logic sys_clk,reset_n,sample_valid,sample_ready,format_twos,sleep,paths_enabled,
  sink_ready,input wire logic [13:0] sample_word,pos_current_path,neg_current_path);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic ok=sink_ready&&!sleep,tk=ok&&sample_valid&&sample_ready,f=format_twos;
  wire logic [13:0] d=sample_word,p=pos_current_path,n=neg_current_path,c={d[13]^f,d[12:0]};
  AST_CAP: assert property(tk##1 ok|=>p==$past(c,2)) else $error("cap");
  AST_LAT: assert property(tk##1 ok|=>n==~$past(c,2)) else $error("lat");
  AST_BIN: assert property(tk&&!f##1 ok|=>p==$past(d,2)) else $error("bin");
  AST_TWOS: assert property(tk&&f##1 ok|=>p[13]!=$past(d[13],2)) else $error("twos");
  AST_FULL: assert property(paths_enabled&&p==14'h3fff|->n==14'h0000) else $error("full");
  AST_COMP: assert property(paths_enabled&&(p|n)!=0|->n==~p) else $error("comp");
  AST_SLEEP: assert property(sleep|=>p==0&&n==0&&!paths_enabled) else $error("sleep");
  AST_FMT: assert property(tk&&f!=$past(f)##1 ok|=>p[13]==$past(c[13],2)) else $error("fmt");
endmodule // dac_props
bind dac_sample_input_interface dac_props chk(.*);
`default_nettype wire

// ### verif/sample_source.sv
// source model; callers enter its tasks just after a rising edge
`default_nettype none
module sample_source(input wire logic sys_clk,sample_ready,
  output logic [13:0] sample_word=14'h0000,output logic sample_valid=1'b0);
  timeunit 1ns/1ns;
  task put(logic [13:0] w,output bit ok);
    sample_valid=1;
    sample_word=w;
    ok=0;
    for(int k=0;k<40&&!ok;k++)
    begin
      ok=sample_ready;
      @(posedge sys_clk);
      #1;
    end
  endtask
  // released lines show the inverse, so a stale word cannot pass
  task idle;
    sample_valid=0;
    sample_word=~sample_word;
  endtask
endmodule // sample_source
`default_nettype wire

// ### verif/dac_sample_input_interface_test.sv
// bench for the sample path; the source model drives words
`default_nettype none
module dac_sample_input_interface_test;
  timeunit 1ns/1ns;
  logic sys_clk=0,reset_n=0,format_twos=0,sleep=0,sink_ready=1,sample_ready,sample_valid,paths_enabled;
  logic [13:0] sample_word,pos_current_path,neg_current_path;
  int failures=0,compares=0,i;
  bit ok=1;
  dac_sample_input_interface uut(.*);
  sample_source src(.*);
  always #10 sys_clk=~sys_clk;
  task chk(string s,logic [28:0] g,e);
    compares++;
    failures+=(g!==e);
    if(g!==e)
      $display("unexpected %s exp %h got %h",s,e,g);
  endtask
  task end_sim;
    $display("compares %0d failures %0d",compares,failures);
    if(failures==0&&compares>0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task xfer(logic [13:0] w,c);
    src.put(w,ok);
    src.idle;
    repeat(6) @(posedge sys_clk);
    #1 chk("path",{ok,pos_current_path,neg_current_path},{1'b1,c,~c});
  endtask
  task t_fmt;
    for(i=0;i<4;i++)
    begin
      format_twos=i[1];
      xfer({14{i[0]}},{i[1]^i[0],{13{i[0]}}});
    end
    $display("formats done");
  endtask
  // stalled sink with sleep on: buffer must refuse, paths read zero
  task t_stall;
    sink_ready=0;
    sleep=1;
    format_twos=0;
    for(i=1;i<9&&ok;i++)
      src.put(14'(i),ok);
    src.idle;
    chk("stall",{ok,pos_current_path,neg_current_path},29'h0);
    sink_ready=1;
    sleep=0;
    xfer(14'(i-1),14'(i-1));
    $display("stall done");
  endtask
  initial
  begin
    repeat(8) @(posedge sys_clk);
    #1 reset_n=1;
    t_fmt;
    t_stall;
    end_sim;
  end
endmodule // dac_sample_input_interface_test
`default_nettype wire
